// >>> design/sync_serial_port.sv
// Synchronous serial port: master or slave shift engine for SPI, SSI
// and three-wire formats, with transmit and receive frame FIFOs.
// Assumes pins are resolved outside from out/oe pairs; link clock is
// slow enough (several core_clk cycles per half bit) to be oversampled.
//
// Functional notes
// - Port works as master or as slave
// - Eight-frame transmit and receive FIFOs
// - Frame length selectable from 4 to 16
// - Full duplex: equal frames both directions
// - One master, one slave per transfer
// - Master makes clock, slave samples it
// - SPI selects clock polarity, others idle low
// - Clock toggles only while frame moves
// - Master asserts select before data, releases after; SSI pulses it before data
// - Select active level follows frame format
// - Slave accepts data only while selected; SSI slave shifts after the select pulse
// - Slave drives MISO, master samples it
// - Unselected slave leaves MISO undriven, but SSI drives it while busy
// - Master drives MOSI, slave samples it
`include "sync_serial_cfg.svh"
`timescale 1ns/1ps
`default_nettype none
module sync_serial_port #(
    parameter int DATA_W     = `SSP_DATA_W,
    parameter int FIFO_DEPTH = `SSP_FIFO_DEPTH,
    parameter int HALF_CYC   = `SSP_HALF_CYC
) (
    input  wire logic                       core_clk,
    input  wire logic                       reset,
    input  wire logic                       clk_en,
    input  wire logic                       master_mode,
    input  wire sync_serial_pkg::frame_fmt_t frame_format,
    input  wire logic                       clk_polarity,
    input  wire logic                       clk_phase,
    input  wire logic [`SSP_LEN_W-1:0]      data_size,
    input  wire logic                       tx_valid,
    output logic                            tx_ready,
    input  wire logic [DATA_W-1:0]          tx_data,
    output logic                            rx_valid,
    input  wire logic                       rx_ready,
    output logic      [DATA_W-1:0]          rx_data,
    output logic                            rx_overrun,
    output logic                            busy,
    input  wire logic                       sck_in,
    output logic                            sck_out,
    output logic                            sck_oe,
    input  wire logic                       frame_sync_line_in,
    output logic                            frame_sync_line_out,
    output logic                            frame_sync_line_oe,
    input  wire logic                       miso_in,
    output logic                            miso_out,
    output logic                            miso_oe,
    input  wire logic                       mosi_in,
    output logic                            mosi_out,
    output logic                            mosi_oe
);
    import sync_serial_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // Declarations

    state_t                 state_reg;
    logic [`SSP_CNT_W-1:0]  half_cnt_reg;
    logic                   phase_reg;
    logic [`SSP_LEN_W-1:0]  bit_cnt_reg;
    logic                   sck_reg;
    logic                   sck_prev_reg;
    logic                   sel_act_reg;
    logic                   push_reg;
    logic                   out_bit_reg;
    logic [DATA_W-1:0]      tx_sh_reg;
    logic [DATA_W-1:0]      tx_sh_next;
    logic [DATA_W-1:0]      rx_sh_reg;
    logic [`SSP_SYNC_W-1:0] pin_s;
    logic                   sck_s;
    logic                   sel_s;
    logic                   miso_s;
    logic                   mosi_s;
    logic                   tx_q_valid;
    logic [DATA_W-1:0]      tx_q_data;
    logic                   rx_in_ready;
    logic                   is_spi;
    logic                   is_ssi;
    logic                   idle_lvl;
    logic                   cpha_eff;
    logic                   sel_on;
    logic [`SSP_LEN_W-1:0]  len_m1;
    logic                   tick;
    logic                   lead;
    logic                   trail;
    logic                   sample;
    logic                   shift;
    logic                   last;
    logic                   in_bit;
    logic                   m_start;
    logic                   s_start;
    logic                   s_abort;
    logic                   load;

    // Sizes below four bits are not supported; treat them as four
    function automatic logic [`SSP_LEN_W-1:0] len_clamp(
        input logic [`SSP_LEN_W-1:0] sz
    );
        return (sz < `SSP_LEN_MIN) ? `SSP_LEN_MIN : sz;
    endfunction : len_clamp

    ////////////////////////////////////////////////////////////////////
    // Pin synchronisers and FIFOs

    // Select resets high so an idle non-SSI slave is not falsely addressed
    pin_sync #(
        .WIDTH (`SSP_SYNC_W),
        .INIT  (`SSP_PIN_INIT)
    ) u_pin_sync (
        .core_clk (core_clk),
        .reset    (reset),
        .d        ({sck_in, frame_sync_line_in, miso_in, mosi_in}),
        .q        (pin_s)
    );

    assign sck_s  = pin_s[3];
    assign sel_s  = pin_s[2];
    assign miso_s = pin_s[1];
    assign mosi_s = pin_s[0];

    // Outgoing frames wait here until the engine takes them
    frame_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_tx_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .in_valid  (tx_valid),
        .in_ready  (tx_ready),
        .in_data   (tx_data),
        .out_valid (tx_q_valid),
        .out_ready (load),
        .out_data  (tx_q_data)
    );

    // Completed frames wait here for the user side
    frame_fifo #(
        .WIDTH (DATA_W),
        .DEPTH (FIFO_DEPTH)
    ) u_rx_fifo (
        .core_clk  (core_clk),
        .reset     (reset),
        .clk_en    (clk_en),
        .in_valid  (push_reg),
        .in_ready  (rx_in_ready),
        .in_data   (rx_sh_reg),
        .out_valid (rx_valid),
        .out_ready (rx_ready),
        .out_data  (rx_data)
    );

    ////////////////////////////////////////////////////////////////////
    // Format decode and shift events

    // Only SPI may idle the clock high; select is high-active for SSI
    assign is_spi   = (frame_format == FMT_SPI);
    assign is_ssi   = (frame_format == FMT_SSI);
    assign idle_lvl = is_spi ? clk_polarity : 1'b0;
    assign cpha_eff = is_spi ? clk_phase : is_ssi;
    assign sel_on   = is_ssi ? sel_s : !sel_s;
    assign len_m1   = len_clamp(data_size);
    assign tick     = (half_cnt_reg == `SSP_CNT_W'(HALF_CYC - 1));

    // Master edges come from its divider; slave edges from the pin
    always_comb
    begin
        lead  = 1'b0;
        trail = 1'b0;
        if (state_reg == ST_SHIFT)
        begin
            if (master_mode)
            begin
                lead  = tick && !phase_reg;
                trail = tick && phase_reg;
            end
            else if (sck_s != sck_prev_reg)
            begin
                lead  = (sck_s != idle_lvl);
                trail = (sck_s == idle_lvl);
            end
        end
    end

    // Sample and shift edges are swapped by the clock phase
    assign sample = cpha_eff ? trail : lead;
    assign shift  = cpha_eff ? (lead && bit_cnt_reg != '0)
                             : (trail && bit_cnt_reg != len_m1);
    assign last   = trail && (bit_cnt_reg == len_m1);
    assign in_bit = master_mode ? miso_s : mosi_s;

    // A master waits for receive room so no frame is ever lost
    assign m_start = master_mode && (state_reg == ST_IDLE)
                     && tx_q_valid && rx_in_ready;
    assign s_start = !master_mode && (state_reg == ST_IDLE) && sel_on;
    assign s_abort = !master_mode && !is_ssi
                     && (state_reg != ST_IDLE) && !sel_on;
    assign load    = m_start || s_start;

    ////////////////////////////////////////////////////////////////////
    // Sequencer

    // Idle, select lead-in, shifting, and release or wait-for-deselect
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            state_reg <= ST_IDLE;
        else if (clk_en)
        begin
            case (state_reg)
                ST_IDLE:
                begin
                    if (m_start)
                        state_reg <= ST_LEAD;
                    else if (s_start)
                        state_reg <= is_ssi ? ST_LEAD : ST_SHIFT;
                end
                ST_LEAD:
                begin
                    if (master_mode ? tick : !sel_s)
                        state_reg <= ST_SHIFT;
                end
                ST_SHIFT:
                begin
                    if (s_abort)
                        state_reg <= ST_IDLE;
                    else if (last)
                        state_reg <= ST_TRAIL;
                end
                ST_TRAIL:
                begin
                    if (master_mode ? tick : (is_ssi || !sel_on))
                        state_reg <= ST_IDLE;
                end
                default:
                    state_reg <= ST_IDLE;
            endcase
        end
    end

    // Half-bit divider runs only while the master has a frame going
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            half_cnt_reg <= '0;
        else if (clk_en)
        begin
            if (!master_mode || state_reg == ST_IDLE || tick)
                half_cnt_reg <= '0;
            else
                half_cnt_reg <= half_cnt_reg + 1'b1;
        end
    end

    // Bit phase and bit count, shared by both roles
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            phase_reg   <= 1'b0;
            bit_cnt_reg <= '0;
        end
        else if (clk_en)
        begin
            if (state_reg != ST_SHIFT || lead)
                phase_reg <= (state_reg == ST_SHIFT);
            else if (trail)
                phase_reg <= 1'b0;
            if (load)
                bit_cnt_reg <= '0;
            else if (trail && !last)
                bit_cnt_reg <= bit_cnt_reg + 1'b1;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // Link pins

    // Clock rests at its idle level outside the shifting state
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            sck_reg      <= 1'b0;
            sck_prev_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            sck_prev_reg <= sck_s;
            if (!master_mode || state_reg != ST_SHIFT)
                sck_reg <= idle_lvl;
            else if (tick)
                sck_reg <= !sck_reg;
        end
    end

    // Select goes active with the frame; SSI only pulses it before data
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            sel_act_reg <= 1'b0;
        else if (clk_en)
        begin
            if (!master_mode)
                sel_act_reg <= 1'b0;
            else if (m_start)
                sel_act_reg <= 1'b1;
            else if (state_reg == ST_LEAD && tick && is_ssi)
                sel_act_reg <= 1'b0;
            else if (state_reg == ST_TRAIL && tick)
                sel_act_reg <= 1'b0;
        end
    end

    // Pins are driven only in the role that owns them
    assign sck_out             = sck_reg;
    assign sck_oe              = master_mode;
    assign frame_sync_line_out = sel_act_reg ? is_ssi : !is_ssi;
    assign frame_sync_line_oe  = master_mode;
    assign mosi_out            = out_bit_reg;
    assign mosi_oe             = master_mode;
    assign miso_out            = out_bit_reg;
    assign miso_oe             = !master_mode
                                 && (is_ssi ? state_reg != ST_IDLE : sel_on);
    assign busy                = (state_reg != ST_IDLE);

    ////////////////////////////////////////////////////////////////////
    // Data path

    // An empty transmit FIFO sends zeros rather than stalling a slave
    always_comb
    begin
        tx_sh_next = tx_sh_reg;
        if (load)
            tx_sh_next = tx_q_valid ? tx_q_data : '0;
        else if (shift)
            tx_sh_next = {tx_sh_reg[DATA_W-2:0], 1'b0};
    end

    // Frames leave MSB first from the selected length's top bit
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            tx_sh_reg   <= '0;
            out_bit_reg <= 1'b0;
        end
        else if (clk_en)
        begin
            tx_sh_reg   <= tx_sh_next;
            out_bit_reg <= tx_sh_next[len_m1];
        end
    end

    // Receive shifter is cleared per frame, so short frames are right-aligned
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            rx_sh_reg <= '0;
            push_reg  <= 1'b0;
        end
        else if (clk_en)
        begin
            if (load)
                rx_sh_reg <= '0;
            else if (sample)
                rx_sh_reg <= {rx_sh_reg[DATA_W-2:0], in_bit};
            push_reg <= last;
        end
    end

    // A slave cannot hold off its master, so a full FIFO drops the frame
    assign rx_overrun = push_reg && !rx_in_ready;

    ////////////////////////////////////////////////////////////////////
    // Assertions

    // Outside a frame the clock may only settle onto a new idle level
    sck_quiet_a: assert property (@(posedge core_clk) disable iff (reset)
        (master_mode && $past(master_mode) && $changed(sck_out))
        |-> ($past(state_reg) == ST_SHIFT) || (sck_out == $past(idle_lvl)))
        else $error("clock moved outside a frame");

    idle_level_a: assert property (@(posedge core_clk) disable iff (reset)
        (master_mode && !is_spi && state_reg == ST_IDLE
         && $past(state_reg) == ST_IDLE && $stable(frame_format))
        |-> !sck_out)
        else $error("non-SPI clock not idle low");

    sel_lead_a: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && m_start) |=> (state_reg == ST_LEAD) && sel_act_reg)
        else $error("select not active before data");

    sel_release_a: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && master_mode && state_reg == ST_TRAIL && tick)
        |=> !sel_act_reg && state_reg == ST_IDLE)
        else $error("select not released after frame");

    sel_level_a: assert property (@(posedge core_clk) disable iff (reset)
        (master_mode && state_reg == ST_SHIFT && $stable(frame_format))
        |-> frame_sync_line_out == 1'b0)
        else $error("select level wrong while shifting");

    frame_length_a: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && last) |=> push_reg && $past(bit_cnt_reg) == $past(len_m1))
        else $error("frame length mismatch");

    slave_abort_a: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && s_abort) |=> state_reg == ST_IDLE)
        else $error("slave kept shifting after deselect");

    miso_hiz_a: assert property (@(posedge core_clk) disable iff (reset)
        (!master_mode && !is_ssi && sel_s) |-> !miso_oe)
        else $error("unselected slave drives MISO");

    role_pins_a: assert property (@(posedge core_clk) disable iff (reset)
        master_mode |-> sck_oe && mosi_oe && !miso_oe)
        else $error("master pin directions wrong");

    tx_pop_a: assert property (@(posedge core_clk) disable iff (reset)
        (clk_en && m_start)
        |-> tx_q_valid && load ##1 mosi_out == $past(tx_q_data[len_m1]))
        else $error("master frame not taken from FIFO");
endmodule : sync_serial_port
`default_nettype wire

// >>> design/sync_serial_cfg.svh
// Constants for the synchronous serial port: frame sizes, FIFO depth,
// bit timing and pin reset levels.
// Assumes inclusion by bare name from every design file that needs it.
`ifndef SYNC_SERIAL_CFG_SVH
`define SYNC_SERIAL_CFG_SVH

`define SSP_DATA_W      16
`define SSP_LEN_W       4
`define SSP_LEN_MIN     4'h3
`define SSP_FIFO_DEPTH  8
`define SSP_HALF_CYC    10
`define SSP_SYNC_W      4
`define SSP_PIN_INIT    4'h4
`define SSP_CNT_W       16

`endif

// >>> design/sync_serial_pkg.sv
// Types shared by the synchronous serial port design files.
// Assumes nothing beyond a SystemVerilog compiler.
package sync_serial_pkg;

    // Frame formats selectable on the port
    typedef enum logic [1:0] {
        FMT_SPI = 2'b00,
        FMT_SSI = 2'b01,
        FMT_MW  = 2'b10
    } frame_fmt_t;

    // Shift engine states, shared by master and slave roles
    typedef enum logic [1:0] {
        ST_IDLE  = 2'b00,
        ST_LEAD  = 2'b01,
        ST_SHIFT = 2'b10,
        ST_TRAIL = 2'b11
    } state_t;

endpackage : sync_serial_pkg

// >>> design/pin_sync.sv
// Two-stage synchroniser for pins arriving from outside core_clk.
// Assumes the sampled signals change slowly compared to core_clk.
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int              WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic [WIDTH-1:0] d,
    output logic      [WIDTH-1:0] q
);
    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            meta_reg <= INIT;
            q        <= INIT;
        end
        else
        begin
            meta_reg <= d;
            q        <= meta_reg;
        end
    end
endmodule : pin_sync
`default_nettype wire

// >>> design/frame_fifo.sv
// Frame FIFO with valid/ready on both sides and honest full/empty.
// Assumes a single clock; clk_en low freezes all state.
`timescale 1ns/1ps
`default_nettype none
module frame_fifo #(
    parameter int WIDTH = 16,
    parameter int DEPTH = 8
) (
    input  wire logic             core_clk,
    input  wire logic             reset,
    input  wire logic             clk_en,
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             wr_go;
    logic             rd_go;

    // Full refuses writes, empty hides data
    assign in_ready  = (count_reg != (AW+1)'(DEPTH)) && clk_en;
    assign out_valid = (count_reg != '0) && clk_en;
    assign wr_go     = in_valid && in_ready;
    assign rd_go     = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_reg];

    // Storage array, written at the tail
    always_ff @(posedge core_clk)
    begin
        if (wr_go)
            mem[wr_ptr_reg] <= in_data;
    end

    // Pointers wrap at DEPTH, so DEPTH need not be a power of two
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end
        else if (clk_en)
        begin
            if (wr_go)
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
            if (rd_go)
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
            if (wr_go && !rd_go)
                count_reg <= count_reg + 1'b1;
            else if (rd_go && !wr_go)
                count_reg <= count_reg - 1'b1;
        end
    end
endmodule : frame_fifo
`default_nettype wire

// >>> sim/spi_peer.sv
// Behavioural serial slave that faces the port while the port is master.
// Assumes the serial clock, select and master-out line come from the port.
`timescale 1ns/1ps
`default_nettype none
module spi_peer (
    input  wire logic        sck,
    input  wire logic        sel_n,
    input  wire logic        mosi,
    input  wire logic        pol,
    input  wire logic [3:0]  size,
    input  wire logic [15:0] word,
    output logic             miso,
    output logic [15:0]      got
);
    int n;
    initial
    begin
        miso = 1'b0;
        got  = '0;
        n    = 0;
    end
    //////////////////////////////////////////////////////////////////////
    // Select loads the reply; once released the line shows the inverse
    always @(sel_n)
    begin
        if (!sel_n)
        begin
            n    = int'(size);
            miso = word[size];
            got  = '0;
        end
        else
            miso = ~miso;
    end
    // Clock is only sampled here, never driven, so a slave cannot fight it
    always @(sck)
    begin
        if (!sel_n && (sck ^ pol))
            got = {got[14:0], mosi};
        else if (!sel_n && n > 0)
        begin
            n    = n - 1;
            miso = word[n];
        end
    end
endmodule : spi_peer
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the serial port in master and slave roles.
// Assumes the design files are compiled first; the bench resolves pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import sync_serial_pkg::*;
    localparam int H = 10;
    logic        core_clk = 0, reset = 1, clk_en = 0, master_mode = 1;
    logic        pol = 0, tx_valid = 0, rx_ready = 0;
    frame_fmt_t  fmt = FMT_SPI;
    logic [3:0]  size = 4'h7;
    logic [15:0] tx_data = '0, peer_word = '0, rx_data, peer_got, got;
    logic        tx_ready, rx_valid, busy, sck_o, sck_oe, sel_o, sel_oe;
    logic        miso_o, miso_oe, mosi_o, mosi_oe, peer_miso;
    logic        tb_sck = 0, tb_sel = 1, tb_mosi = 0;
    logic        ovr, ovr_seen = 0;
    int          miscompares = 0, compares = 0;
    // Each wire follows whoever has its enable up
    wire logic   sck_w  = sck_oe ? sck_o : tb_sck;
    wire logic   sel_w  = sel_oe ? sel_o : tb_sel;
    wire logic   mosi_w = mosi_oe ? mosi_o : tb_mosi;
    wire logic   miso_w = miso_oe ? miso_o : peer_miso;
    //////////////////////////////////////////////////////////////////////
    sync_serial_port i_dut (.core_clk(core_clk), .reset(reset), .clk_en(clk_en),
        .master_mode(master_mode), .frame_format(fmt), .clk_polarity(pol),
        .clk_phase(1'b0), .data_size(size), .tx_valid(tx_valid), .tx_ready(tx_ready),
        .tx_data(tx_data), .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_data(rx_data),
        .rx_overrun(ovr), .busy(busy), .sck_in(sck_w), .sck_out(sck_o), .sck_oe(sck_oe),
        .frame_sync_line_in(sel_w), .frame_sync_line_out(sel_o),
        .frame_sync_line_oe(sel_oe), .miso_in(miso_w), .miso_out(miso_o),
        .miso_oe(miso_oe), .mosi_in(mosi_w), .mosi_out(mosi_o), .mosi_oe(mosi_oe));
    spi_peer i_peer (.sck(sck_w), .sel_n(sel_w), .mosi(mosi_w), .pol(pol),
        .size(size), .word(peer_word), .miso(peer_miso), .got(peer_got));
    // Core clock, 8 ns period
    always #4 core_clk = ~core_clk;
    // Overrun is a one-cycle pulse, so latch it for a later compare
    always @(posedge core_clk)
        if (ovr === 1'b1)
            ovr_seen <= 1'b1;
    //////////////////////////////////////////////////////////////////////
    // Inputs move 1 ns after the edge so no race with sampling
    task automatic cyc(input int k);
        repeat (k) @(posedge core_clk);
        #1;
    endtask : cyc
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        compares++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : chk
    task automatic test_done();
        $display("compares=%0d miscompares=%0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : test_done
    // Bounded wait; running out counts as a mismatch and ends the run
    task automatic wait_for(ref logic s, input logic v);
        int i;
        for (i = 0; i < 4000 && s !== v; i++)
            cyc(1);
        if (s !== v)
        begin
            miscompares++;
            test_done();
        end
    endtask : wait_for
    //////////////////////////////////////////////////////////////////////
    // Port as master against the peer model, one frame each way
    task automatic master_xfer(input frame_fmt_t f, input logic [3:0] sz,
                               input logic p, input logic [15:0] tw, pw);
        logic [15:0] m;
        m = 16'hffff >> (4'hf - sz);
        master_mode = 1;
        fmt = f;
        size = sz;
        pol = p;
        peer_word = pw;
        cyc(3);
        chk(sck_o, p);
        tx_data = tw;
        tx_valid = 1;
        cyc(1);
        tx_valid = 0;
        wait_for(busy, 1);
        cyc(5);
        chk(sel_o, 0);
        chk(sck_o, p);
        wait_for(rx_valid, 1);
        chk(rx_data, pw & m);
        chk(peer_got, tw & m);
        rx_ready = 1;
        cyc(1);
        rx_ready = 0;
        wait_for(busy, 0);
        chk(sel_o, 1);
        chk(sck_o, p);
    endtask : master_xfer
    // Port as slave: fill the transmit FIFO, then clock one frame in
    task automatic slave_xfer();
        int n;
        int i;
        logic [15:0] sent = 16'h005a;
        master_mode = 0;
        fmt = FMT_SPI;
        size = 4'h7;
        pol = 0;
        cyc(3);
        chk(miso_oe, 0);
        chk(mosi_oe, 0);
        tx_valid = 1;
        for (n = 0; n < 10; n++)
        begin
            tx_data = 16'h0010 + 16'(n);
            if (tx_ready !== 1)
                break;
            cyc(1);
        end
        tx_valid = 0;
        chk(16'(n), 16'h0008);
        tb_sel = 0;
        got = '0;
        cyc(H);
        chk(miso_oe, 1);
        for (i = 7; i >= 0; i--)
        begin
            tb_mosi = sent[i];
            cyc(H);
            tb_sck = 1;
            cyc(H - 1);
            got = {got[14:0], miso_w};
            cyc(1);
            tb_sck = 0;
        end
        cyc(H);
        tb_sel = 1;
        tb_mosi = ~tb_mosi;
        wait_for(rx_valid, 1);
        chk(rx_data, sent);
        chk(got, 16'h0010);
        rx_ready = 1;
        cyc(1);
        rx_ready = 0;
        cyc(3);
        chk(tx_ready, 1);
        chk(ovr_seen, 0);
    endtask : slave_xfer
    //////////////////////////////////////////////////////////////////////
    // Main sequence: reset for 4 cycles, then the scenarios
    initial
    begin
        repeat (4) @(posedge core_clk);
        #1;
        reset = 0;
        clk_en = 1;
        cyc(1);
        master_xfer(FMT_SPI, 4'h3, 1'b0, 16'h000a, 16'h0005);
        master_xfer(FMT_SPI, 4'hf, 1'b1, 16'hbeef, 16'h1234);
        master_xfer(FMT_MW, 4'h7, 1'b0, 16'h00a5, 16'h003c);
        fmt = FMT_SSI;
        pol = 1;
        cyc(3);
        chk(sck_o, 0);
        chk(sel_o, 0);
        slave_xfer();
        test_done();
    end
endmodule : tb_top
`default_nettype wire
